/* logic/srb_reg_bank.sv */
`include "srb_defs.svh"

module srb_reg_bank #(
  parameter int         FRAME_BITS = `SRB_FRAME_BITS,
  parameter logic [7:0] FAMILY_ID  = 8'h5a  // arbitrary value
) (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // serial pins
  input  wire srb_pkg::srb_spi_pins_s        spi_i,
  output logic                               sdo_o,
  output logic                               sdo_oe_o,
  // device side
  input  wire logic                          restart_i,
  input  wire srb_pkg::srb_hw_upd_s          hw_upd_i,
  input  wire logic [0:`SRB_NSTAT-1][7:0]    stat_evt_i,
  input  wire logic [7:0]                    wake_lvl_i,
  output logic [0:`SRB_NCTRL-1][7:0]         ctrl_o,
  output logic                               soft_reset_o
);

  localparam int NC = `SRB_NCTRL;
  localparam int NS = `SRB_NSTAT;
  localparam logic [4:0] FRAME_LEN = 5'(`SRB_FRAME_BITS);
  localparam logic [4:0] OVER_LEN  = 5'(`SRB_FRAME_BITS + 1);
  localparam logic [4:0] ADDR_DONE = 5'(`SRB_ADDR_BITS);
  localparam logic [4:0] DATA_POS  = 5'(`SRB_DATA_LSB);
  localparam logic [0:NC-1][6:0] CTRL_ADDR  = `SRB_CTRL_ADDR;
  localparam logic [0:NC-1][7:0] CTRL_WMASK = `SRB_CTRL_WMASK;
  localparam logic [0:NC-1][7:0] CTRL_RST   = `SRB_CTRL_RST;
  localparam logic [0:NC-1][7:0] CTRL_RSTRT = `SRB_CTRL_RSTRT;
  localparam logic [0:NC-1][7:0] CTRL_KEEP  = `SRB_CTRL_KEEP;
  localparam logic [0:NC-1][7:0] CTRL_HW    = `SRB_CTRL_HW;
  localparam logic [0:NS-1][6:0] STAT_ADDR  = `SRB_STAT_ADDR;
  localparam logic [0:NS-1][7:0] STAT_MASK  = `SRB_STAT_MASK;

  if (FRAME_BITS != `SRB_FRAME_BITS) begin : g_chk
    $error("frame length other than 16 bits is not supported");
  end

  // address decode, used for the read byte and for the commit
  function automatic srb_pkg::srb_dec_s decode(input logic [6:0] a);
    srb_pkg::srb_dec_s d;
    d.kind = srb_pkg::K_NONE;
    d.idx  = 5'h00;
    for (int i = 0; i < NC; i++) begin
      if (CTRL_ADDR[i] == a) begin
        d.kind = srb_pkg::K_CTRL;
        d.idx  = 5'(i);
      end
    end
    for (int i = 0; i < NS; i++) begin
      if (STAT_ADDR[i] == a) begin
        d.kind = srb_pkg::K_STAT;
        d.idx  = 5'(i);
      end
    end
    if (a == `SRB_ADDR_WAKE_LVL) begin
      d.kind = srb_pkg::K_LVL;
    end
    if (a == `SRB_ADDR_FAMILY) begin
      d.kind = srb_pkg::K_FAM;
    end
    return d;
  endfunction

  // pin synchronisers: stage 0 feeds stage 1 only, stage 2 is for sck edges (unused on cs_n)
  logic [2:0] sck_sync_reg, sck_sync_next;
  logic [2:0] csn_sync_reg, csn_sync_next;
  logic [1:0] sdi_sync_reg, sdi_sync_next;

  always_comb begin
    sck_sync_next = {sck_sync_reg[1:0], spi_i.sck};
    csn_sync_next = {csn_sync_reg[1:0], spi_i.cs_n};
    sdi_sync_next = {sdi_sync_reg[0], spi_i.sdi};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_sync_reg <= 3'h0;
      csn_sync_reg <= 3'h7;
      sdi_sync_reg <= 2'h0;
    end else begin
      sck_sync_reg <= sck_sync_next;
      csn_sync_reg <= csn_sync_next;
      sdi_sync_reg <= sdi_sync_next;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_low;
  logic sdi_bit;

  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  assign cs_low   = ~csn_sync_reg[1];
  assign sdi_bit  = sdi_sync_reg[1];

  // register storage
  logic [0:NC-1][7:0] ctrl_reg, ctrl_next;
  logic [0:NS-1][7:0] stat_reg, stat_next;
  logic               soft_reg, soft_next;

  // serial frame engine state
  srb_pkg::srb_state_e state_reg, state_next;
  logic [4:0]          cnt_reg, cnt_next;
  logic [15:0]         rx_reg, rx_next;
  logic [15:0]         tx_reg, tx_next;
  logic                sdo_reg, sdo_next;
  logic                oe_reg, oe_next;
  logic                commit_reg, commit_next;

  // read byte of the register being addressed
  srb_pkg::srb_dec_s dec;
  logic [7:0]        rd_data;
  logic [7:0]        summary;

  assign dec = decode(rx_reg[6:0]);

  always_comb begin
    rd_data = 8'h00;
    unique case (dec.kind)
      srb_pkg::K_CTRL: rd_data = ctrl_reg[dec.idx] & CTRL_WMASK[dec.idx];
      srb_pkg::K_STAT: rd_data = stat_reg[dec.idx] & STAT_MASK[dec.idx];
      srb_pkg::K_LVL:  rd_data = wake_lvl_i & `SRB_WAKE_LVL_MASK;
      srb_pkg::K_FAM:  rd_data = FAMILY_ID;
      srb_pkg::K_NONE: rd_data = 8'h00;
      default:         rd_data = 8'h00;
    endcase
    for (int i = 0; i < 8; i++) begin
      summary[i] = |stat_reg[i];
    end
  end

  // frame engine: sample on rising clock edge, shift out on falling, lsb first
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    rx_next     = rx_reg;
    tx_next     = tx_reg;
    sdo_next    = sdo_reg;
    oe_next     = oe_reg;
    commit_next = 1'b0;
    unique case (state_reg)
      srb_pkg::ST_IDLE: begin
        if (cs_low) begin
          state_next = srb_pkg::ST_SHIFT;
          cnt_next   = 5'h00;
          rx_next    = 16'h0000;
          tx_next    = {8'h00, summary};
          sdo_next   = summary[0];
          oe_next    = 1'b1;
        end
      end
      srb_pkg::ST_SHIFT: begin
        if (!cs_low) begin
          state_next  = srb_pkg::ST_IDLE;
          oe_next     = 1'b0;
          sdo_next    = 1'b0;
          commit_next = (cnt_reg == FRAME_LEN);
        end else begin
          if (sck_rise) begin
            if (cnt_reg < FRAME_LEN) begin
              rx_next[cnt_reg[3:0]] = sdi_bit;
              cnt_next = cnt_reg + 5'h01;
            end else begin
              cnt_next = OVER_LEN;
            end
            if (cnt_reg == ADDR_DONE) begin
              tx_next[15:8] = rd_data;
            end
          end
          if (sck_fall) begin
            sdo_next = (cnt_reg < FRAME_LEN) ? tx_reg[cnt_reg[3:0]] : 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg  <= srb_pkg::ST_IDLE;
      cnt_reg    <= 5'h00;
      rx_reg     <= 16'h0000;
      tx_reg     <= 16'h0000;
      sdo_reg    <= 1'b0;
      oe_reg     <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      rx_reg     <= rx_next;
      tx_reg     <= tx_next;
      sdo_reg    <= sdo_next;
      oe_reg     <= oe_next;
      commit_reg <= commit_next;
    end
  end

  // register file update: soft reset, then restart, then serial write, then hardware
  logic       wr_cmd;
  logic [7:0] clr_mask;

  assign wr_cmd = rx_reg[`SRB_WRITE_BIT];

  always_comb begin
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    soft_next = 1'b0;
    clr_mask  = 8'h00;
    if (soft_reg) begin
      ctrl_next = CTRL_RST;
      stat_next = '0;
    end else begin
      if (restart_i) begin
        for (int i = 0; i < NC; i++) begin
          ctrl_next[i] = (ctrl_reg[i] & CTRL_KEEP[i]) | (CTRL_RSTRT[i] & ~CTRL_KEEP[i]);
        end
      end else if (commit_reg && wr_cmd && dec.kind == srb_pkg::K_CTRL) begin
        ctrl_next[dec.idx] = rx_reg[15:8] & CTRL_WMASK[dec.idx];
        soft_next = (dec.idx == 5'h00) && (rx_reg[15:14] == `SRB_MODE_SOFT_RESET);
      end
      if (hw_upd_i.valid && hw_upd_i.idx < 5'(NC)) begin
        ctrl_next[hw_upd_i.idx] = (ctrl_next[hw_upd_i.idx] & ~CTRL_HW[hw_upd_i.idx])
                                | (hw_upd_i.data & CTRL_HW[hw_upd_i.idx]);
      end
      for (int i = 0; i < NS; i++) begin
        clr_mask = 8'h00;
        if (commit_reg && !wr_cmd && dec.kind == srb_pkg::K_STAT && dec.idx == 5'(i)) begin
          clr_mask = tx_reg[15:8];
        end
        stat_next[i] = ((stat_reg[i] & ~clr_mask) | stat_evt_i[i]) & STAT_MASK[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
      stat_reg <= '0;
      soft_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      soft_reg <= soft_next;
    end
  end

  assign sdo_o        = sdo_reg;
  assign sdo_oe_o     = oe_reg;
  assign ctrl_o       = ctrl_reg;
  assign soft_reset_o = soft_reg;

  // checks
  logic quiet;
  assign quiet = !soft_reg && !restart_i && !hw_upd_i.valid;

  AST_SOFT_RESET_LOADS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_reg |=> (ctrl_reg == CTRL_RST) && (stat_reg == '0))
    else $error("soft reset did not load reset values");

  AST_RESTART_VALUES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (restart_i && !soft_reg && !hw_upd_i.valid) |=>
      ctrl_reg[0] == (($past(ctrl_reg[0]) & CTRL_KEEP[0]) | (CTRL_RSTRT[0] & ~CTRL_KEEP[0])))
    else $error("restart value wrong in mode register");

  AST_FRAME_LENGTH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    commit_reg |-> (cnt_reg == FRAME_LEN) && (state_reg == srb_pkg::ST_IDLE))
    else $error("frame committed with wrong bit count");

  AST_WRITE_BYTE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (commit_reg && wr_cmd && dec.kind == srb_pkg::K_CTRL && quiet) |=>
      ctrl_reg[$past(dec.idx)] == ($past(rx_reg[15:8]) & CTRL_WMASK[$past(dec.idx)]))
    else $error("write byte not stored");

  AST_DATA_ORDER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && cs_low && sck_rise && cnt_reg == DATA_POS) |=>
      rx_reg[8] == $past(sdi_bit))
    else $error("first data bit not at frame bit 8");

  AST_READ_NO_CHANGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (commit_reg && !wr_cmd && quiet) |=> $stable(ctrl_reg))
    else $error("read changed a control register");

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && cnt_reg > DATA_POS && dec.kind == srb_pkg::K_CTRL) |->
      (tx_reg[15:8] & ~CTRL_WMASK[dec.idx]) == 8'h00)
    else $error("reserved bit read as one");

  AST_STATUS_WRITE_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (commit_reg && wr_cmd && dec.kind == srb_pkg::K_STAT && !soft_reg && stat_evt_i == '0) |=>
      $stable(stat_reg))
    else $error("write changed a read-only register");

  AST_HOLD_VALUE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!commit_reg && quiet) |=> $stable(ctrl_reg))
    else $error("control register changed without a write");

  AST_OLD_DATA_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && cnt_reg > DATA_POS && !commit_reg) |=> $stable(tx_reg[15:8]))
    else $error("returned data byte changed within frame");

  AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (commit_reg && !wr_cmd && dec.kind == srb_pkg::K_STAT && !soft_reg) |=>
      (stat_reg[$past(dec.idx)] & $past(tx_reg[15:8]) & ~$past(stat_evt_i[dec.idx])) == 8'h00)
    else $error("reported flags not cleared");

  AST_UNMAPPED_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (commit_reg && dec.kind == srb_pkg::K_NONE && quiet) |=> $stable(ctrl_reg))
    else $error("unmapped access changed a register");

  AST_FRAME_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_IDLE && cs_low) |=> sdo_oe_o && (sdo_o == $past(summary[0])))
    else $error("frame start did not enable the serial output");

  AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_IDLE && !cs_low) |=> !sdo_oe_o && !sdo_o)
    else $error("serial output driven outside a frame");

  AST_CUT_FRAME_DROPPED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && !cs_low && cnt_reg != FRAME_LEN) |=> !commit_reg)
    else $error("frame of wrong length committed");

  AST_OVERRUN_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && cs_low && sck_rise && cnt_reg >= FRAME_LEN) |=>
      (cnt_reg == OVER_LEN) && $stable(rx_reg))
    else $error("extra clock edge changed the frame");

  AST_SDO_BIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && cs_low && sck_fall && cnt_reg < FRAME_LEN) |=>
      sdo_o == $past(tx_reg[cnt_reg[3:0]]))
    else $error("serial output bit out of order");

  AST_CAPTURE_OLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == srb_pkg::ST_SHIFT && cs_low && sck_rise && cnt_reg == ADDR_DONE) |=>
      tx_reg[15:8] == $past(rd_data))
    else $error("returned byte not captured from the register");

  AST_SOFT_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_reg |=> !soft_reg)
    else $error("soft reset pulse longer than one cycle");

  AST_SOFT_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_reg |-> $past(commit_reg && wr_cmd && dec.kind == srb_pkg::K_CTRL && dec.idx == 5'h00 &&
                       rx_reg[15:14] == `SRB_MODE_SOFT_RESET && !restart_i && !soft_reg))
    else $error("soft reset without a mode write");

  AST_RESTART_STATUS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (restart_i && !soft_reg && !commit_reg && stat_evt_i == '0) |=> $stable(stat_reg))
    else $error("restart changed a status register");

  AST_HW_UPDATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hw_upd_i.valid && hw_upd_i.idx < 5'(NC) && !soft_reg && !restart_i && !commit_reg) |=>
      ctrl_reg[$past(hw_upd_i.idx)] == (($past(ctrl_reg[hw_upd_i.idx]) & ~CTRL_HW[$past(hw_upd_i.idx)])
                                       | ($past(hw_upd_i.data) & CTRL_HW[$past(hw_upd_i.idx)])))
    else $error("hardware update wrote a plain bit");

  AST_HW_RANGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hw_upd_i.valid && hw_upd_i.idx >= 5'(NC) && !soft_reg && !restart_i && !commit_reg) |=>
      $stable(ctrl_reg))
    else $error("hardware update outside the control registers");

  for (genvar g = 0; g < NS; g++) begin : g_flag
    AST_FLAG_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !soft_reg |=> (stat_reg[g] & $past(stat_evt_i[g]) & STAT_MASK[g]) == ($past(stat_evt_i[g]) & STAT_MASK[g]))
      else $error("status event lost");

    AST_FLAG_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (stat_reg[g] & ~STAT_MASK[g]) == 8'h00)
      else $error("reserved status bit set");
  end

endmodule // srb_reg_bank

/* logic/srb_defs.svh */
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH

// frame layout
`define SRB_FRAME_BITS      16
`define SRB_ADDR_BITS       7
`define SRB_WRITE_BIT       7
`define SRB_DATA_LSB        8
`define SRB_MODE_SOFT_RESET 2'b11

// register counts
`define SRB_NCTRL 17
`define SRB_NSTAT 9

// control registers, index 0 first
`define SRB_CTRL_ADDR {7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0c, 7'h10, 7'h14, 7'h15, \
                       7'h17, 7'h18, 7'h19, 7'h1c, 7'h1e}
`define SRB_CTRL_WMASK {8'hff, 8'hfb, 8'hf7, 8'he3, 8'hc4, 8'ha7, 8'h3f, 8'h7f, 8'h77, 8'h30, 8'h77, 8'h77, \
                        8'hff, 8'hff, 8'hff, 8'h05, 8'hff}
`define SRB_CTRL_RST   {17{8'h00}}
`define SRB_CTRL_RSTRT {17{8'h00}}
`define SRB_CTRL_KEEP  {8'h23, 8'hd9, {15{8'hff}}}
`define SRB_CTRL_HW    {8'hfc, 8'h20, {15{8'h00}}}

// read/clear status registers, index 0 first
`define SRB_STAT_ADDR {7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h47, 7'h54, 7'h55}
`define SRB_STAT_MASK {8'hff, 8'hff, 8'h07, 8'hc7, 8'h67, 8'hf7, 8'h30, 8'h0f, 8'h0f}

// read-only registers
`define SRB_ADDR_WAKE_LVL 7'h48
`define SRB_WAKE_LVL_MASK 8'hf7
`define SRB_ADDR_FAMILY   7'h7e

`endif

/* logic/srb_pkg.sv */
package srb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } srb_state_e;

  typedef enum logic [4:0] {
    K_NONE = 5'b00001,
    K_CTRL = 5'b00010,
    K_STAT = 5'b00100,
    K_LVL  = 5'b01000,
    K_FAM  = 5'b10000
  } srb_kind_e;

  typedef struct packed {
    srb_kind_e   kind;
    logic [4:0]  idx;
  } srb_dec_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [7:0]  data;
  } srb_hw_upd_s;

  typedef struct packed {
    logic        sck;
    logic        cs_n;
    logic        sdi;
  } srb_spi_pins_s;

endpackage : srb_pkg

/* tb/srb_spi_master.sv */
// serial master: mode 0, lsb first, sck half period 8 clk
module srb_spi_master (
  // clock
  input  wire logic                   clk_i,
  // serial pins
  output srb_pkg::srb_spi_pins_s      spi_o,
  input  wire logic                   sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 8;

  initial begin
    spi_o = '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0};
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // sdi turns to the inverse of its last level outside frames
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = '0;
    spi_o.cs_n <= 1'b0;
    spi_o.sdi  <= tx[0];
    for (int b = 0; b < n; b++) begin
      wait_clk(HALF);
      spi_o.sck <= 1'b1;
      if (b < 16) begin
        rx[b] = sdo_i;
      end
      wait_clk(HALF);
      spi_o.sck <= 1'b0;
      spi_o.sdi <= (b < 15) ? tx[b+1] : ~tx[15];
    end
    wait_clk(HALF);
    spi_o.cs_n <= 1'b1;
    spi_o.sdi  <= ~spi_o.sdi;
    wait_clk(HALF);
  endtask
endmodule // srb_spi_master

/* tb/tb.sv */
`include "srb_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                          clk_i;
  logic                          rst_n_i;
  srb_pkg::srb_spi_pins_s        spi;
  logic                          sdo_o;
  logic                          sdo_oe_o;
  logic                          restart_i;
  srb_pkg::srb_hw_upd_s          hw_upd_i;
  logic [0:`SRB_NSTAT-1][7:0]    stat_evt_i;
  logic [7:0]                    wake_lvl_i;
  logic [0:`SRB_NCTRL-1][7:0]    ctrl_o;
  logic                          soft_reset_o;
  logic [0:16][6:0]              ca = `SRB_CTRL_ADDR;
  logic [0:16][7:0]              wm = `SRB_CTRL_WMASK;
  logic [0:8][6:0]               sa = `SRB_STAT_ADDR;
  logic [0:8][7:0]               sm = `SRB_STAT_MASK;
  logic [0:16][7:0]              exp_c;
  logic [15:0]                   r;
  int                            error_cnt;
  int                            checks_done;
  int                            soft_cnt;

  srb_reg_bank #(.FAMILY_ID(8'ha5)) srb_reg_bank_inst (  // family value arbitrary
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .spi_i       (spi),
    .sdo_o       (sdo_o),
    .sdo_oe_o    (sdo_oe_o),
    .restart_i   (restart_i),
    .hw_upd_i    (hw_upd_i),
    .stat_evt_i  (stat_evt_i),
    .wake_lvl_i  (wake_lvl_i),
    .ctrl_o      (ctrl_o),
    .soft_reset_o(soft_reset_o)
  );

  srb_spi_master srb_spi_master_inst (
    .clk_i(clk_i),
    .spi_o(spi),
    .sdo_i(sdo_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (soft_reset_o === 1'b1) soft_cnt <= soft_cnt + 1;
  end

  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpv(input logic [0:16][7:0] got, input logic [0:16][7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d);
    srb_spi_master_inst.xfer({d, w, a}, 16, r);
  endtask

  task automatic t_reset;
    cmpv(ctrl_o, '0);
    cmp8({sdo_oe_o, sdo_o, soft_reset_o, 5'h00}, 8'h00);
    acc(7'h03, 1'b0, 8'h00);
    cmp8(r[15:8], 8'h00);
  endtask

  task automatic t_ctrl;
    for (int i = 0; i < 17; i++) begin
      acc(ca[i], 1'b1, (i == 0) ? 8'h7f : 8'hff);
      exp_c[i] = ((i == 0) ? 8'h7f : 8'hff) & wm[i];
      cmpv(ctrl_o, exp_c);
      acc(ca[i], 1'b0, 8'h00);
      cmp8(r[15:8], exp_c[i]);
      cmpv(ctrl_o, exp_c);
    end
    acc(ca[3], 1'b1, 8'h00);
    cmp8(r[15:8], exp_c[3]);
    exp_c[3] = 8'h00;
    cmpv(ctrl_o, exp_c);
  endtask

  task automatic t_refused;
    acc(7'h05, 1'b1, 8'hff);
    cmpv(ctrl_o, exp_c);
    acc(7'h05, 1'b0, 8'h00);
    cmp8(r[15:8], 8'h00);
    srb_spi_master_inst.xfer({8'h00, 1'b1, 7'h06}, 15, r);
    cmpv(ctrl_o, exp_c);
    srb_spi_master_inst.xfer({8'h00, 1'b1, 7'h06}, 17, r);
    cmpv(ctrl_o, exp_c);
  endtask

  task automatic t_status;
    wake_lvl_i <= 8'hff;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i) stat_evt_i[i] <= 8'hff;
      @(posedge clk_i) stat_evt_i[i] <= 8'h00;
      acc(sa[i], 1'b0, 8'h00);
      cmp8(r[15:8], sm[i]);
      cmp8(r[7:0], (i < 8) ? (8'h01 << i) : 8'h00);
      acc(sa[i], 1'b0, 8'h00);
      cmp8(r[15:8], 8'h00);
    end
    acc(7'h48, 1'b1, 8'h00);
    acc(7'h48, 1'b0, 8'h00);
    cmp8(r[15:8], 8'hf7);
    acc(7'h7e, 1'b0, 8'h00);
    cmp8(r[15:8], 8'ha5);
  endtask

  task automatic t_restart;
    @(posedge clk_i) restart_i <= 1'b1;
    @(posedge clk_i) restart_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    exp_c[0] = exp_c[0] & 8'h23;
    exp_c[1] = exp_c[1] & 8'hd9;
    cmpv(ctrl_o, exp_c);
  endtask

  task automatic t_hw;
    @(posedge clk_i) hw_upd_i <= {1'b1, 5'd0, 8'h80};
    @(posedge clk_i) hw_upd_i <= {1'b1, 5'd2, 8'hff};
    @(posedge clk_i) hw_upd_i <= {1'b1, 5'd1, 8'hff};
    @(posedge clk_i) hw_upd_i <= {1'b1, 5'd20, 8'hff};
    @(posedge clk_i) hw_upd_i <= '0;
    repeat (3) @(posedge clk_i);
    exp_c[0] = 8'h83;
    exp_c[1] = exp_c[1] | 8'h20;
    cmpv(ctrl_o, exp_c);
  endtask

  task automatic t_soft;
    @(posedge clk_i) stat_evt_i[1] <= 8'h01;
    @(posedge clk_i) stat_evt_i[1] <= 8'h00;
    acc(7'h01, 1'b1, 8'hc0);
    cmp8(r[15:8], exp_c[0]);
    repeat (4) @(posedge clk_i);
    cmp8(8'(soft_cnt), 8'h01);
    cmpv(ctrl_o, '0);
    acc(7'h41, 1'b0, 8'h00);
    cmp8(r[15:8], 8'h00);
  endtask

  initial begin
    rst_n_i    = 1'b0;
    restart_i  = 1'b0;
    hw_upd_i   = '0;
    stat_evt_i = '0;
    wake_lvl_i = 8'h00;
    exp_c      = '0;
    error_cnt  = 0;
    checks_done = 0;
    soft_cnt   = 0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_ctrl();
    t_refused();
    t_status();
    t_restart();
    t_hw();
    t_soft();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
endmodule // tb
